// [logic/hbcr_bank_sel.sv]
// Bank decoder: picks the lowest bank whose cumulative top exceeds the address.
// Assumes tops are programmed monotone; a miss flags no bank.
`timescale 1ns/1ps
module hbcr_bank_sel #(
    parameter int BANKS = 4
) (
    input wire logic [35:0] addr,
    input wire logic [BANKS*10-1:0] tops,
    output logic [BANKS-1:0] hit_onehot,
    output logic hit_any
);
    import hbcr_pkg::*;

    logic [BANKS-1:0] below;

    // Address below each cumulative top
    for (genvar i = 0; i < BANKS; i++) begin : g_cmp
        assign below[i] =
            (addr >> TOP_SHIFT) < {26'h0, tops[i*10 +: 10]};
    end

    // First bank the address falls under wins
    always_comb begin
        hit_onehot = below & ~(below << 1);
        hit_any = |below;
    end
endmodule

// [logic/hbcr_pkg.sv]
// Constants, field positions and carrier types for the bridge config block.
// Assumes a plain register port with one-cycle strobes and byte offsets.
//
// How it works
// - At reset release, address lines 12:5 are latched into the strap capture.
// - Capture bits 12:11 hold the interrupt cluster identifier.
// - Capture bits 10, 9, 8 gate the bus-init, bus-error, address-error inputs.
// - Capture bit 7 set limits the in-order queue to 1, else 8.
// - Capture bits 6 and 5 are recorded only, with no effect here.
// - Bank config bit 15 selects 4:1 interleave, else 2:1; resets to one.
// - Bank config bit 14 set means one row; clear means two; resets zero.
// - Refresh goes only to banks whose present bit 13 is set; resets one.
// - Bank chosen by comparing address to cumulative 10-bit top, 32 MB units.
// - Device map bits 14:0 flag devices 16-30 on bus 0 present.
// - Device map resets to 0005h; bit 0 is fixed at one, read-only.
// - Gap-enable bit 4 opens the low expansion gap; resets zero.
// - Bit 3 routes the 2 MB below 4 GB to the compatibility bus.
// - Bit 2 routes B0000h-BFFFFh to the compatibility bus.
// - Bit 1 routes A0000h-AFFFFh to the compatibility bus.
// - Header layout register ignores writes and reads 00h.
package hbcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int BANKS = 4;
    localparam int SYS_ADDR_W = 36;

    // Register byte offsets
    localparam logic [7:0] OFS_HEADER = 8'h0E;
    localparam logic [7:0] OFS_STRAP = 8'h4E;
    localparam logic [7:0] OFS_DEV_MAP = 8'hD6;
    localparam logic [7:0] OFS_GAPEN = 8'h60;
    localparam logic [7:0] OFS_BANK0 = 8'h80;
    localparam logic [7:0] OFS_STATUS = 8'h88;

    // Reset values
    localparam logic [15:0] RST_STRAP = 16'h0000;
    localparam logic [15:0] RST_DEV_MAP = 16'h0005;
    localparam logic [15:0] RST_BANK = 16'hA200;
    localparam logic [7:0] RST_GAPEN = 8'h0E;
    localparam logic [7:0] HEADER_VAL = 8'h00;

    // Field masks and positions
    localparam logic [15:0] STRAP_MASK = 16'h1FE0;
    localparam logic [15:0] DEV_MAP_MASK = 16'h7FFF;
    localparam logic [15:0] BANK_MASK = 16'hE3FF;
    localparam logic [7:0] GAPEN_MASK = 8'h1E;
    localparam int STRAP_IOQ = 7;
    localparam int STRAP_ADDR_ERR = 8;
    localparam int STRAP_BUS_ERR = 9;
    localparam int STRAP_BUS_INIT = 10;
    localparam int BANK_ILV4 = 15;
    localparam int BANK_SROW = 14;
    localparam int BANK_PRES = 13;
    localparam int GAP_LOW_GAP = 4;
    localparam int GAP_HBIOS = 3;
    localparam int GAP_HGFX = 2;
    localparam int GAP_LGFX = 1;
    localparam int TOP_SHIFT = 25;
    localparam logic [3:0] IOQ_DEEP = 4'h8;
    localparam logic [3:0] IOQ_SHALLOW = 4'h1;

    // Decoded regions
    localparam logic [35:0] HBIOS_BASE = 36'h0FFE00000;
    localparam logic [35:0] HBIOS_TOP = 36'h0FFFFFFFF;
    localparam logic [35:0] LGFX_BASE = 36'h0000A0000;
    localparam logic [35:0] HGFX_BASE = 36'h0000B0000;
    localparam logic [35:0] GFX_SIZE = 36'h000010000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } hbcr_req_t;

    typedef struct packed {
        logic bus_init;
        logic bus_err;
        logic addr_err;
    } hbcr_err_t;
endpackage

// [logic/hbcr_top.sv]
// Configuration register bank of a host bridge: straps, DRAM banks, gap
// enables, device map, header. Register port is a plain strobe port.
`timescale 1ns/1ps
module hbcr_top #(
    parameter int BANKS = hbcr_pkg::BANKS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire hbcr_pkg::hbcr_req_t req,
    output logic [hbcr_pkg::DATA_W-1:0] rdata,
    input wire logic [15:0] sys_addr_low,
    input wire hbcr_pkg::hbcr_err_t err_in,
    output hbcr_pkg::hbcr_err_t err_seen,
    output logic [3:0] ioq_depth,
    output logic [1:0] cluster_id,
    input wire logic [35:0] acc_addr,
    output logic to_compat_bus,
    output logic low_gap_en,
    output logic [BANKS-1:0] bank_hit,
    output logic [BANKS-1:0] refresh_enable,
    output logic [BANKS-1:0] bank_ilv4,
    output logic [BANKS-1:0] bank_single_row,
    output logic [14:0] dev_present
);
    import hbcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic in_rst;
        logic [15:0] strap;
        logic [15:0] dev_map;
        logic [7:0] gapen;
        logic [BANKS-1:0][15:0] bank;
        logic [15:0] rdata;
        hbcr_err_t err_seen;
        logic [3:0] ioq;
        logic compat;
        logic [BANKS-1:0] hit;
    } hbcr_state_t;

    hbcr_state_t st_ff;
    hbcr_state_t nxt_st;
    logic [BANKS-1:0] sel_onehot;
    logic sel_any;
    logic [BANKS*10-1:0] tops;

    ////////////////////////////////////////////////////////////////////////
    // Bank decode
    for (genvar i = 0; i < BANKS; i++) begin : g_tops
        assign tops[i*10 +: 10] = st_ff.bank[i][9:0];
    end

    hbcr_bank_sel #(
        .BANKS(BANKS)
    ) u_sel (
        .addr(acc_addr),
        .tops(tops),
        .hit_onehot(sel_onehot),
        .hit_any(sel_any)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic hb;
        logic hg;
        logic lg;
        hb = 1'b0;
        hg = 1'b0;
        lg = 1'b0;
        nxt_st = st_ff;
        nxt_st.in_rst = 1'b0;
        // Latch straps on first cycle after reset release
        if (st_ff.in_rst) begin
            nxt_st.strap = sys_addr_low & STRAP_MASK;
        end
        // Writes; strap and header have no write path
        if (req.wr) begin
            if (req.addr == OFS_DEV_MAP) begin
                nxt_st.dev_map = (req.wdata & DEV_MAP_MASK)
                    | (RST_DEV_MAP & 16'h0001);
            end
            if (req.addr == OFS_GAPEN) begin
                nxt_st.gapen = req.wdata[7:0] & GAPEN_MASK;
            end
            for (int i = 0; i < BANKS; i++) begin
                if (req.addr == OFS_BANK0 + 8'(2 * i)) begin
                    nxt_st.bank[i] = req.wdata & BANK_MASK;
                end
            end
        end
        // Read data valid only in the cycle after the strobe
        nxt_st.rdata = 16'h0000;
        if (req.rd) begin
            case (req.addr)
                OFS_HEADER: nxt_st.rdata = {8'h00, HEADER_VAL};
                OFS_STRAP: nxt_st.rdata = st_ff.strap;
                OFS_DEV_MAP: nxt_st.rdata = st_ff.dev_map;
                OFS_GAPEN: nxt_st.rdata = {8'h00, st_ff.gapen};
                OFS_STATUS: nxt_st.rdata = {12'h000, st_ff.ioq};
                default: nxt_st.rdata = 16'h0000;
            endcase
            for (int i = 0; i < BANKS; i++) begin
                if (req.addr == OFS_BANK0 + 8'(2 * i)) begin
                    nxt_st.rdata = st_ff.bank[i];
                end
            end
        end
        // Error inputs gated by captured enables
        nxt_st.err_seen.bus_init =
            err_in.bus_init & st_ff.strap[STRAP_BUS_INIT];
        nxt_st.err_seen.bus_err =
            err_in.bus_err & st_ff.strap[STRAP_BUS_ERR];
        nxt_st.err_seen.addr_err =
            err_in.addr_err & st_ff.strap[STRAP_ADDR_ERR];
        nxt_st.ioq = st_ff.strap[STRAP_IOQ] ? IOQ_SHALLOW : IOQ_DEEP;
        // Compatibility routing windows
        hb = st_ff.gapen[GAP_HBIOS] && acc_addr >= HBIOS_BASE
            && acc_addr <= HBIOS_TOP;
        hg = st_ff.gapen[GAP_HGFX] && acc_addr >= HGFX_BASE
            && acc_addr < HGFX_BASE + GFX_SIZE;
        lg = st_ff.gapen[GAP_LGFX] && acc_addr >= LGFX_BASE
            && acc_addr < LGFX_BASE + GFX_SIZE;
        nxt_st.compat = hb | hg | lg;
        // Routed-away accesses select no memory bank
        nxt_st.hit = (nxt_st.compat || !sel_any) ? '0 : sel_onehot;
        if (!rstn) begin
            nxt_st.in_rst = 1'b1;
            nxt_st.strap = RST_STRAP;
            nxt_st.dev_map = RST_DEV_MAP;
            nxt_st.gapen = RST_GAPEN;
            for (int i = 0; i < BANKS; i++) begin
                nxt_st.bank[i] = RST_BANK;
            end
            nxt_st.rdata = 16'h0000;
            nxt_st.err_seen = '0;
            nxt_st.ioq = IOQ_DEEP;
            nxt_st.compat = 1'b0;
            nxt_st.hit = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk) begin
        st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    always_comb begin
        rdata = st_ff.rdata;
        err_seen = st_ff.err_seen;
        ioq_depth = st_ff.ioq;
        cluster_id = st_ff.strap[12:11];
        to_compat_bus = st_ff.compat;
        low_gap_en = st_ff.gapen[GAP_LOW_GAP];
        bank_hit = st_ff.hit;
        dev_present = st_ff.dev_map[14:0];
        for (int i = 0; i < BANKS; i++) begin
            refresh_enable[i] = st_ff.bank[i][BANK_PRES];
            bank_ilv4[i] = st_ff.bank[i][BANK_ILV4];
            bank_single_row[i] = st_ff.bank[i][BANK_SROW];
        end
    end
endmodule

// [sim/hbcr_props.sv]
// Port checker for the bridge config block.
// Assumes one clock and a sync active-low reset.
`timescale 1ns/1ps
module hbcr_props
#(parameter int BANKS = 4)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire hbcr_pkg::hbcr_req_t req,
    input wire logic [15:0] rdata,
    input wire logic [15:0] sys_addr_low,
    input wire hbcr_pkg::hbcr_err_t err_in,
    input wire hbcr_pkg::hbcr_err_t err_seen,
    input wire logic [3:0] ioq_depth,
    input wire logic [1:0] cluster_id,
    input wire logic low_gap_en,
    input wire logic [BANKS-1:0] bank_hit,
    input wire logic [BANKS-1:0] refresh_enable,
    input wire logic [14:0] dev_present
);
    import hbcr_pkg::*;
    logic [1:0] cnt_ff;
    logic [15:0] cap_ff;
    ////////////////////////////////////////////////////////////////////////
    // Own strap copy; checks wait 3 edges so output latency is no issue
    always_ff @(posedge sys_clk) begin
        if (!rstn)
            cnt_ff <= 2'h0;
        else if (cnt_ff != 2'h3)
            cnt_ff <= cnt_ff + 2'h1;
        if (rstn && cnt_ff == 2'h0)
            cap_ff <= sys_addr_low;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // A write, then a quiet cycle so the value can be traced
    sequence s_wr(logic [7:0] a);
        req.wr && req.addr == a ##1 !req.wr;
    endsequence
    AST_HEADER: assert property (req.rd && req.addr == OFS_HEADER |=>
        rdata == 16'h0000) else $error("header read");
    AST_STRAP: assert property (req.rd && req.addr == OFS_STRAP &&
        cnt_ff == 2'h3 |=> rdata == (cap_ff & STRAP_MASK)) else $error("strap");
    AST_CLUSTER: assert property (cnt_ff == 2'h3 |->
        cluster_id == cap_ff[12:11]) else $error("cluster");
    AST_IOQ: assert property (cnt_ff == 2'h3 |->
        ioq_depth == (cap_ff[7] ? IOQ_SHALLOW : IOQ_DEEP)) else $error("ioq");
    AST_ERR: assert property (cnt_ff == 2'h3 |=>
        err_seen == ($past(err_in) & cap_ff[10:8])) else $error("err gate");
    AST_ONEHOT: assert property ($onehot0(bank_hit))
        else $error("bank hit");
    AST_BANK: assert property (s_wr(OFS_BANK0) |=>
        refresh_enable[0] == $past(req.wdata[13], 2)) else $error("present");
    AST_GAP: assert property (s_wr(OFS_GAPEN) |=>
        low_gap_en == $past(req.wdata[4], 2)) else $error("low gap");
    // Own entry stays present whatever software writes
    AST_DEV_BIT0: assert property (dev_present[0])
        else $error("device map bit 0");
endmodule
bind hbcr_top hbcr_props #(.BANKS(BANKS)) hbcr_props_inst (.*);

// [sim/hbcr_strap_agent.sv]
// Bus agent that drives strap values on the low address lines.
// Assumes the block samples them on the first edge after release.
`timescale 1ns/1ps
module hbcr_strap_agent (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [15:0] strap_val,
    output logic [15:0] sys_addr_low
);
    logic hold_ff;
    // Hold one edge past release, then flip so a late sample shows
    always_ff @(posedge sys_clk) begin
        hold_ff <= !rstn;
    end
    assign sys_addr_low = (!rstn || hold_ff) ? strap_val : ~strap_val;
endmodule

// [sim/testbench.sv]
// Self-checking bench for the bridge config block.
// Assumes the strap agent and the bound port checker.
`timescale 1ns/1ps
module testbench;
    import hbcr_pkg::*;
    logic sys_clk, rstn, to_compat_bus, low_gap_en;
    hbcr_req_t req;
    hbcr_err_t err_in, err_seen;
    logic [15:0] rdata, strap_val, sys_addr_low;
    logic [3:0] ioq_depth, bank_hit, refresh_enable, bank_ilv4;
    logic [3:0] bank_single_row;
    logic [1:0] cluster_id;
    logic [35:0] acc_addr;
    logic [14:0] dev_present;
    int bad_count, n_compared;
    logic [23:0] rows [10] = '{{OFS_HEADER, 16'h0000}, {OFS_STRAP, 16'h1FE0},
        {OFS_DEV_MAP, 16'h0005}, {OFS_GAPEN, 16'h000E}, {8'h80, 16'hA200},
        {8'h82, 16'hA200}, {8'h84, 16'hA200}, {8'h86, 16'hA200},
        {8'h10, 16'h0000}, {OFS_STATUS, 16'h0001}};
    logic [35:0] win [4] = '{36'h0, LGFX_BASE, HGFX_BASE, HBIOS_BASE};
    hbcr_top hbcr_top_inst (.*);
    hbcr_strap_agent hbcr_strap_agent_inst (.*);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bus cycles: strobe for one edge; read data stand one cycle only
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask
    task automatic do_reset(input logic [15:0] v);
        @(posedge sys_clk);
        rstn <= 1'b0;
        strap_val <= v;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        step(4);
        cmp({14'h0, cluster_id}, {14'h0, v[12:11]});
        cmp({12'h0, ioq_depth}, v[7] ? 16'h1 : 16'h8);
    endtask
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end
    initial begin
        {rstn, req, err_in, acc_addr, bad_count, n_compared} = '0;
        strap_val = 16'hFFFF;
        do_reset(16'hFFFF);
        foreach (rows[i]) rd(rows[i][23:16], rows[i][15:0]);
        wr(OFS_HEADER, 16'hFFFF);
        rd(OFS_HEADER, 16'h0000);
        wr(OFS_STRAP, 16'h0000);
        rd(OFS_STRAP, 16'h1FE0);
        wr(OFS_DEV_MAP, 16'hFFFE);
        rd(OFS_DEV_MAP, 16'h7FFF);
        cmp({1'b0, dev_present}, 16'h7FFF);
        // Each window alone routes only its own range
        for (int b = 1; b < 4; b++) begin
            wr(OFS_GAPEN, 16'h1 << b);
            for (int a = 0; a < 4; a++) begin
                @(posedge sys_clk);
                acc_addr <= win[a];
                step(2);
                cmp({15'h0, to_compat_bus}, {15'h0, a == b});
            end
        end
        // Bank 1 one-row, unfitted, zero size; bank 0 two-way interleave
        wr(OFS_GAPEN, 16'h0010);
        wr(OFS_BANK0, 16'h2001);
        wr(8'h82, 16'hC001);
        @(posedge sys_clk);
        acc_addr <= 36'h002000000;
        err_in <= 3'b101;
        step(2);
        cmp({15'h0, low_gap_en}, 16'h0001);
        cmp({12'h0, bank_hit}, 16'h0004);
        cmp({12'h0, refresh_enable}, 16'h000D);
        cmp({12'h0, bank_ilv4}, 16'h000E);
        cmp({12'h0, bank_single_row}, 16'h0002);
        cmp({13'h0, err_seen}, 16'h0005);
        // Bank 0 marked absent: refresh must stop there
        wr(OFS_BANK0, 16'h0001);
        rd(OFS_BANK0, 16'h0001);
        cmp({12'h0, refresh_enable}, 16'h000C);
        // Second reset: only bus-error observed, address-error left off
        do_reset(16'h0A40);
        rd(OFS_STRAP, 16'h0A40);
        cmp({13'h0, err_seen}, 16'h0000);
        @(posedge sys_clk);
        err_in <= 3'b111;
        step(2);
        cmp({13'h0, err_seen}, 16'h0002);
        rd(8'h80, 16'hA200);
        complete_run();
    end
endmodule
